// ### include/adcsq_consts.svh
// Constants of the two-channel converter sequencer: SFR offsets,
// field positions, reset values and conversion timing.
// Guarded, so any number of files may include it in one compilation unit.
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH

// ----------------------------------------------------------------
// SFR offsets
// ----------------------------------------------------------------
`define ADCSQ_OFS_CLKDIV 8'hF2
`define ADCSQ_OFS_CTRL   8'hF3
`define ADCSQ_OFS_RESLO  8'hF4
`define ADCSQ_OFS_RESHI  8'hF5

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define ADCSQ_CTRL_IDLE  6
`define ADCSQ_CTRL_EN    5
`define ADCSQ_CTRL_EOC   4
`define ADCSQ_CTRL_START 3
`define ADCSQ_CTRL_CHSEL 0

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define ADCSQ_RST_CLKDIV 8'h00
`define ADCSQ_RST_CTRL   8'h00
`define ADCSQ_RST_RESLO  8'h00
`define ADCSQ_RST_RESHI  8'h00
`define ADCSQ_DIV_W      5
`define ADCSQ_RES_W      10
`define ADCSQ_CONV_TICKS 11

`endif

// ### include/adcsq_pkg.sv
// Types shared by the converter sequencer modules.
// Assumes nothing of its surroundings.
package adcsq_pkg;

  // ----------------------------------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ADCSQ_OFF    = 4'b0001,
    ADCSQ_READY  = 4'b0010,
    ADCSQ_SAMPLE = 4'b0100,
    ADCSQ_CONV   = 4'b1000
  } adcsq_state_e;

  typedef logic [7:0] adcsq_byte_t;

endpackage

// ### design/adcsq_clkdiv.sv
// Converter clock divider: one-cycle tick every N peripheral clocks.
// Assumes a synchronous restart from the sequencer at conversion launch.
`timescale 1ns/1ps
`include "adcsq_consts.svh"

module adcsq_clkdiv import adcsq_pkg::*; #(
  parameter int DIV_W = `ADCSQ_DIV_W
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             restart_i,
  input  wire logic [DIV_W-1:0] div_i,
  output logic                  tick_o
);

  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] reload;

  generate
    if (DIV_W < 2 || DIV_W > 8) begin : g_chk
      $error("adcsq_clkdiv: DIV_W out of range");
    end
  endgenerate

  // A zero divider wraps to all ones, giving the full 2**DIV_W period
  assign reload = div_i - {{(DIV_W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else if (restart_i) begin
      // Reloading at launch puts the first tick exactly N cycles later
      cnt_r <= reload;
      tick_o <= (reload == '0);
    end else if (cnt_r == '0) begin
      cnt_r <= reload;
      tick_o <= (reload == '0);
    end else begin
      cnt_r <= cnt_r - {{(DIV_W-1){1'b0}}, 1'b1};
      tick_o <= (cnt_r == {{(DIV_W-1){1'b0}}, 1'b1});
    end
  end

endmodule

// ### design/adcsq_top.sv
// Converter sequencer: SFR block, clock divider, successive
// approximation sequencing, result registers and CPU freeze.
// Assumes the CPU SFR port runs on mclk_i, and an analog macro that
// follows sample_o, chan_first_o and dac_code_o and returns cmp_i.
`timescale 1ns/1ps
`include "adcsq_consts.svh"

module adcsq_top import adcsq_pkg::*; #(
  parameter int DIV_W = `ADCSQ_DIV_W,
  parameter int RES_W = `ADCSQ_RES_W
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic [7:0]       sfr_addr_i,
  input  wire logic             sfr_wr_i,
  input  wire logic             sfr_rd_i,
  input  wire logic [7:0]       sfr_wdata_i,
  output logic [7:0]            sfr_rdata_o,
  output logic                  sfr_sel_o,
  input  wire logic             conv_irq_en_i,
  input  wire logic             cmp_i,
  output logic                  adc_power_o,
  output logic                  chan_first_o,
  output logic                  sample_o,
  output logic [RES_W-1:0]      dac_code_o,
  output logic                  cpu_freeze_o,
  output logic                  conv_irq_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  generate
    if (RES_W != `ADCSQ_RES_W) begin : g_chk_res
      $error("adcsq_top: result split needs a 10-bit result");
    end
    if (DIV_W < 2 || DIV_W > 8) begin : g_chk_div
      $error("adcsq_top: DIV_W out of range");
    end
    if (`ADCSQ_CONV_TICKS != RES_W + 1) begin : g_chk_ticks
      $error("adcsq_top: one sample tick plus one tick per bit expected");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  logic sel_div;
  logic sel_ctrl;
  logic sel_lo;
  logic sel_hi;
  logic wr_div;
  logic wr_ctrl;

  assign sel_div   = hit(sfr_addr_i, `ADCSQ_OFS_CLKDIV);
  assign sel_ctrl  = hit(sfr_addr_i, `ADCSQ_OFS_CTRL);
  assign sel_lo    = hit(sfr_addr_i, `ADCSQ_OFS_RESLO);
  assign sel_hi    = hit(sfr_addr_i, `ADCSQ_OFS_RESHI);
  assign sfr_sel_o = sel_div | sel_ctrl | sel_lo | sel_hi;
  assign wr_div    = sfr_wr_i & sel_div;
  assign wr_ctrl   = sfr_wr_i & sel_ctrl;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  adcsq_state_e     state_r;
  adcsq_state_e     state_nxt;
  logic [DIV_W-1:0] div_r;
  logic             idle_req_r;
  logic             en_r;
  logic             eoc_r;
  logic             start_r;
  logic             chsel_r;
  logic [3:0]       bit_r;
  logic [RES_W-1:0] sar_r;
  logic [7:0]       res_hi_r;
  logic [1:0]       res_lo_r;
  logic [7:0]       rdata_r;
  logic             cmp_meta_r;
  logic             cmp_s_r;
  logic             tick;
  logic             launch;
  logic             busy;
  logic             last_tick;
  logic             done;
  logic             abort;

  assign busy      = (state_r == ADCSQ_SAMPLE) || (state_r == ADCSQ_CONV);
  assign launch    = wr_ctrl && sfr_wdata_i[`ADCSQ_CTRL_START] &&
                     (state_r == ADCSQ_READY) &&
                     sfr_wdata_i[`ADCSQ_CTRL_EN];
  assign last_tick = tick && (state_r == ADCSQ_CONV) && (bit_r == 4'h0);
  assign done      = last_tick;
  assign abort     = busy && wr_ctrl && !sfr_wdata_i[`ADCSQ_CTRL_EN];

  // ----------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------
  // The analog comparator is not on mclk_i, so two flops guard it;
  // the cost is a two-cycle decision lag, fine for dividers above 2
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cmp_meta_r <= 1'b0;
      cmp_s_r <= 1'b0;
    end else begin
      cmp_meta_r <= cmp_i;
      cmp_s_r <= cmp_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Converter clock
  // ----------------------------------------------------------------
  adcsq_clkdiv #(
    .DIV_W     (DIV_W)
  ) u_div (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .restart_i (launch),
    .div_i     (div_r),
    .tick_o    (tick)
  );

  // ----------------------------------------------------------------
  // Divider register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      div_r <= DIV_W'(`ADCSQ_RST_CLKDIV);
    end else if (wr_div) begin
      div_r <= sfr_wdata_i[DIV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Control register bits
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      en_r <= 1'b0;
      chsel_r <= 1'b0;
    end else if (wr_ctrl) begin
      en_r <= sfr_wdata_i[`ADCSQ_CTRL_EN];
      // Channel is frozen during a conversion so the held sample
      // never changes source half way
      if (!busy) begin
        chsel_r <= sfr_wdata_i[`ADCSQ_CTRL_CHSEL];
      end
    end
  end

  // Start is owned by hardware while busy: writing it zero does not clear it, only completion or an abort by clearing enable
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      start_r <= 1'b0;
    end else if (done || abort) begin
      start_r <= 1'b0;
    end else if (launch) begin
      start_r <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      idle_req_r <= 1'b0;
    end else if (done || abort) begin
      idle_req_r <= 1'b0;
    end else if (wr_ctrl && !busy) begin
      idle_req_r <= sfr_wdata_i[`ADCSQ_CTRL_IDLE];
    end
  end

  // Writing zero clears; a completion in the same cycle wins
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      eoc_r <= 1'b0;
    end else if (done) begin
      eoc_r <= 1'b1;
    end else if (wr_ctrl && !sfr_wdata_i[`ADCSQ_CTRL_EOC]) begin
      eoc_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ADCSQ_OFF: begin
        if (wr_ctrl && sfr_wdata_i[`ADCSQ_CTRL_EN]) begin
          state_nxt = ADCSQ_READY;
        end
      end
      ADCSQ_READY: begin
        if (launch) begin
          state_nxt = ADCSQ_SAMPLE;
        end else if (wr_ctrl && !sfr_wdata_i[`ADCSQ_CTRL_EN]) begin
          state_nxt = ADCSQ_OFF;
        end
      end
      ADCSQ_SAMPLE: begin
        if (abort) begin
          state_nxt = ADCSQ_OFF;
        end else if (tick) begin
          state_nxt = ADCSQ_CONV;
        end
      end
      ADCSQ_CONV: begin
        if (abort) begin
          state_nxt = ADCSQ_OFF;
        end else if (done) begin
          state_nxt = ADCSQ_READY;
        end
      end
      default: begin
        state_nxt = ADCSQ_OFF;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= ADCSQ_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Bit counter
  // ----------------------------------------------------------------
  // One sample period then one period per result bit: 1 + 10 = 11.
  // Ticks fall N, 2N, ... 11N cycles after launch, so the last
  // decision and the result load share the edge 11N after launch
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bit_r <= 4'(RES_W - 1);
    end else if (launch) begin
      bit_r <= 4'(`ADCSQ_CONV_TICKS - 2);
    end else if (tick && state_r == ADCSQ_CONV && bit_r != 4'h0) begin
      bit_r <= bit_r - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Successive approximation register
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < RES_W; gi++) begin : g_sar
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          sar_r[gi] <= 1'b0;
        end else if (launch) begin
          sar_r[gi] <= (gi == RES_W - 1);
        end else if (tick && state_r == ADCSQ_CONV) begin
          if (bit_r == 4'(gi)) begin
            sar_r[gi] <= cmp_s_r;
          end else if (bit_r == 4'(gi + 1)) begin
            sar_r[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Result registers
  // ----------------------------------------------------------------
  // Loaded only on completion, so an aborted run leaves the old value
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      res_hi_r <= `ADCSQ_RST_RESHI;
      res_lo_r <= 2'(`ADCSQ_RST_RESLO);
    end else if (done) begin
      res_hi_r <= sar_r[RES_W-1:2];
      res_lo_r <= {sar_r[1], cmp_s_r};
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Reserved bits are tied low, not stored, so stray ones never read back
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
    end else if (sfr_rd_i) begin
      if (sel_div) begin
        rdata_r <= {{(8-DIV_W){1'b0}}, div_r};
      end else if (sel_ctrl) begin
        rdata_r <= {1'b0, idle_req_r, en_r, eoc_r,
                    start_r, 2'b00, chsel_r};
      end else if (sel_lo) begin
        rdata_r <= {6'h00, res_lo_r};
      end else if (sel_hi) begin
        rdata_r <= res_hi_r;
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end

  assign sfr_rdata_o = rdata_r;

  // ----------------------------------------------------------------
  // Analog side and CPU side outputs
  // ----------------------------------------------------------------
  assign adc_power_o  = en_r;
  assign chan_first_o = chsel_r;
  assign sample_o     = (state_r == ADCSQ_SAMPLE);
  assign dac_code_o   = sar_r;

  // Only the core is frozen; this block and the divider keep counting
  assign cpu_freeze_o = idle_req_r && busy;

  // Held back while the core is frozen, so it is served after the end
  assign conv_irq_o = eoc_r && conv_irq_en_i && !cpu_freeze_o;

endmodule

// ### testbench/adcsq_props.sv
// Port checker for the converter sequencer.
// Assumes it is bound to adcsq_top and sees only that module's ports.
`timescale 1ns/1ps
`include "adcsq_consts.svh"

module adcsq_props import adcsq_pkg::*; #(
  parameter int DIV_W = 5,
  parameter int RES_W = 10
) (
  input wire logic             mclk_i,
  input wire logic             rst_i,
  input wire logic [7:0]       sfr_addr_i,
  input wire logic             sfr_wr_i,
  input wire logic             sfr_rd_i,
  input wire logic [7:0]       sfr_wdata_i,
  input wire logic [7:0]       sfr_rdata_o,
  input wire logic             sfr_sel_o,
  input wire logic             conv_irq_en_i,
  input wire logic             cmp_i,
  input wire logic             adc_power_o,
  input wire logic             chan_first_o,
  input wire logic             sample_o,
  input wire logic [RES_W-1:0] dac_code_o,
  input wire logic             cpu_freeze_o,
  input wire logic             conv_irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Conversion steps
  // ----------------------------------------------------------------
  sequence s_launch;
    $rose(sample_o);
  endsequence

  // Power still on tells a normal end from an abort
  sequence s_done;
    $fell(cpu_freeze_o) ##0 adc_power_o;
  endsequence

  chk_launch_trial: assert property (s_launch |-> adc_power_o && dac_code_o == {1'b1, {(RES_W-1){1'b0}}})
    else $error("first trial code wrong at launch");
  chk_freeze_launch: assert property ($rose(cpu_freeze_o) |-> sample_o)
    else $error("freeze without a launch");
  chk_freeze_release: assert property (s_done |-> conv_irq_o == conv_irq_en_i)
    else $error("held interrupt not released at end");
  chk_irq_gate: assert property (conv_irq_o |-> conv_irq_en_i && !cpu_freeze_o)
    else $error("interrupt while masked or frozen");
  chk_irq_sticky: assert property (conv_irq_o && !sfr_wr_i ##1 conv_irq_en_i |-> conv_irq_o)
    else $error("end flag dropped without software");
  chk_standby_quiet: assert property (!adc_power_o |-> !sample_o && !cpu_freeze_o)
    else $error("activity in standby");
  chk_chan_busy: assert property (cpu_freeze_o && $past(cpu_freeze_o) |-> $stable(chan_first_o))
    else $error("channel changed during conversion");
  chk_unmapped_read: assert property (sfr_rd_i && !sfr_sel_o |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_ctrl_reserved: assert property (sfr_rd_i && sfr_addr_i == `ADCSQ_OFS_CTRL |=> (sfr_rdata_o & 8'h86) == 8'h00)
    else $error("control reserved bits not zero");
endmodule

bind adcsq_top adcsq_props #(.DIV_W(DIV_W), .RES_W(RES_W)) i_adcsq_props (
  .mclk_i(mclk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .sfr_sel_o(sfr_sel_o), .conv_irq_en_i(conv_irq_en_i),
  .cmp_i(cmp_i), .adc_power_o(adc_power_o), .chan_first_o(chan_first_o), .sample_o(sample_o),
  .dac_code_o(dac_code_o), .cpu_freeze_o(cpu_freeze_o), .conv_irq_o(conv_irq_o));

// ### testbench/adcsq_analog_model.sv
// Analog side of the converter: two inputs, sample-and-hold, comparator.
// Assumes sample, channel and trial code come from the sequencer.
`timescale 1ns/1ps

module adcsq_analog_model #(
  parameter int RES_W = 10
) (
  input  wire logic             mclk_i,
  input  wire logic             power_i,
  input  wire logic             sample_i,
  input  wire logic             chan_first_i,
  input  wire logic [RES_W-1:0] dac_code_i,
  input  wire logic [RES_W-1:0] ain_first_i,
  input  wire logic [RES_W-1:0] ain_second_i,
  output logic                  cmp_o
);
  logic [RES_W-1:0] held_r;
  logic             junk_r = 1'b0;

  always @(posedge mclk_i) junk_r <= ~junk_r;

  // Hold tracks the selected input only while sampling
  always_ff @(posedge mclk_i) begin
    if (sample_i) begin
      held_r <= chan_first_i ? ain_first_i : ain_second_i;
    end
  end

  // In standby the comparator means nothing, so it toggles
  assign cmp_o = power_i ? (held_r >= dac_code_i) : junk_r;
endmodule

// ### testbench/testbench.sv
// Self-checking bench for the converter sequencer.
// Assumes the sequencer, the analog model and the checker are compiled first.
`timescale 1ns/1ps
`include "adcsq_consts.svh"

module testbench import adcsq_pkg::*;;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  sfr_addr_i = 8'h00;
  logic        sfr_wr_i = 1'b0;
  logic        sfr_rd_i = 1'b0;
  logic [7:0]  sfr_wdata_i = 8'h00;
  logic        conv_irq_en_i = 1'b0;
  logic [9:0]  ain_first = 10'h000;
  logic [9:0]  ain_second = 10'h000;
  logic [7:0]  sfr_rdata_o;
  logic        sfr_sel_o, cmp_i, adc_power_o, chan_first_o, sample_o, cpu_freeze_o, conv_irq_o;
  logic [9:0]  dac_code_o;
  int          fails = 0;
  int          total_checks = 0;
  int          last_v = 0;
  int          exp_q[$];
  adcsq_byte_t rd_b;

  adcsq_top i_adcsq_top (
    .mclk_i(mclk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .sfr_sel_o(sfr_sel_o), .conv_irq_en_i(conv_irq_en_i),
    .cmp_i(cmp_i), .adc_power_o(adc_power_o), .chan_first_o(chan_first_o), .sample_o(sample_o),
    .dac_code_o(dac_code_o), .cpu_freeze_o(cpu_freeze_o), .conv_irq_o(conv_irq_o));

  adcsq_analog_model i_adcsq_analog_model (
    .mclk_i(mclk_i), .power_i(adc_power_o), .sample_i(sample_o), .chan_first_i(chan_first_o),
    .dac_code_i(dac_code_o), .ain_first_i(ain_first), .ain_second_i(ain_second), .cmp_o(cmp_i));

  // ----------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------
  task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(string what, logic exp, logic got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk_i);
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    sfr_wr_i <= 1'b1;
    @(posedge mclk_i);
    sfr_wr_i <= 1'b0;
  endtask

  // Read data lands on the edge that takes the strobe
  task automatic rdc(logic [7:0] a, logic [7:0] e);
    @(posedge mclk_i);
    sfr_addr_i <= a;
    sfr_rd_i <= 1'b1;
    @(posedge mclk_i);
    sfr_rd_i <= 1'b0;
    #1;
    rd_b = sfr_rdata_o;
    chk8($sformatf("reg %h", a), e, rd_b);
  endtask

  task automatic convert(int div, bit ch, bit idle, bit ien);
    int n;
    n = (div == 0) ? 32 : div;
    ain_first <= 10'($urandom);
    ain_second <= 10'($urandom);
    conv_irq_en_i <= ien;
    wr(`ADCSQ_OFS_CLKDIV, 8'(div));
    wr(`ADCSQ_OFS_CTRL, {7'h10, ch});
    // Setup time after enable is the software's wait
    repeat (4) @(posedge mclk_i);
    exp_q.push_back(int'(ch ? ain_first : ain_second));
    wr(`ADCSQ_OFS_CTRL, {1'b0, idle, 3'b101, 2'b00, ch});
    #1;
    chk1("sampling", 1'b1, sample_o);
    chk1("channel", ch, chan_first_o);
    repeat (11 * n - 1) @(posedge mclk_i);
    #1;
    chk1("frozen", idle, cpu_freeze_o);
    chk1("early irq", 1'b0, conv_irq_o);
    @(posedge mclk_i);
    #1;
    chk1("thawed", 1'b0, cpu_freeze_o);
    chk1("irq", ien, conv_irq_o);
    rdc(`ADCSQ_OFS_CTRL, {7'h18, ch});
    last_v = exp_q.pop_front();
    rdc(`ADCSQ_OFS_RESHI, 8'(last_v >> 2));
    rdc(`ADCSQ_OFS_RESLO, 8'(last_v & 3));
    chk1("irq held", ien, conv_irq_o);
    wr(`ADCSQ_OFS_CTRL, {7'h10, ch});
    rdc(`ADCSQ_OFS_RESHI, 8'(last_v >> 2));
    chk1("irq cleared", 1'b0, conv_irq_o);
    $display("test conversion div %0d done", div);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  initial begin
    repeat (100000) @(posedge mclk_i);
    fails++;
    $display("BAD watchdog expected finish seen timeout");
    test_done();
  end

  initial begin
    int divs[4];
    divs = '{3, 0, 31, 4};
    void'($urandom(96044));
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    for (int a = 'hF1; a <= 'hF6; a++) begin
      rdc(8'(a), 8'h00);
      chk1("select", (a >= 'hF2 && a <= 'hF5), sfr_sel_o);
    end
    $display("test reset done");
    wr(`ADCSQ_OFS_CLKDIV, 8'hFF);
    rdc(`ADCSQ_OFS_CLKDIV, 8'h1F);
    wr(`ADCSQ_OFS_RESLO, 8'hFF);
    wr(`ADCSQ_OFS_RESHI, 8'hFF);
    rdc(`ADCSQ_OFS_RESLO, 8'h00);
    rdc(`ADCSQ_OFS_RESHI, 8'h00);
    wr(`ADCSQ_OFS_CTRL, 8'h81);
    rdc(`ADCSQ_OFS_CTRL, 8'h01);
    // Start from standby is refused, only the enable takes
    wr(`ADCSQ_OFS_CTRL, 8'h28);
    rdc(`ADCSQ_OFS_CTRL, 8'h20);
    chk1("power", 1'b1, adc_power_o);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      if (i < 4) begin
        convert(divs[i], i[0], i[0] ^ i[1], i[1]);
      end else begin
        convert($urandom_range(31, 3), 1'($urandom), 1'($urandom), 1'($urandom));
      end
    end
    wr(`ADCSQ_OFS_CLKDIV, 8'h03);
    wr(`ADCSQ_OFS_CTRL, 8'h20);
    wr(`ADCSQ_OFS_CTRL, 8'h68);
    repeat (9) @(posedge mclk_i);
    #1;
    chk1("frozen", 1'b1, cpu_freeze_o);
    wr(`ADCSQ_OFS_CTRL, 8'h00);
    #1;
    chk1("abort power", 1'b0, adc_power_o);
    repeat (40) @(posedge mclk_i);
    rdc(`ADCSQ_OFS_CTRL, 8'h00);
    rdc(`ADCSQ_OFS_RESHI, 8'(last_v >> 2));
    $display("test abort done");
    test_done();
  end
endmodule
